//--- hdl/ifm_top.sv
// interpolation and complex modulation datapath with axi4-lite registers
// assumes aclk is the dac sample rate: one output sample per cycle
// Contract
// - interleave set: port 1 words alternate i then q and are steered to the i and q paths in that order.
// - interleave set: each channel path runs at half the port word rate, port rate unchanged.
// - real mode: q path and modulation off, i output is port 1 interpolated by 1, 2, 4 or 8.
// - dual channel: outputs are the input times a complex carrier at dac/2, dac/4 or dac/8.
// - filter_config bits 7:6 select the interpolation factor and bits 5:2 the filter mode.
// - 8x: even codes 0..14 give carriers 0, 1/8 .. 1/2 .. -1/8, odd codes shift the band up 1/16.
// - 4x: even codes 0..6 give carriers 0, 1/4, 1/2, -1/4, odd codes shift the band up 1/8.
// - 2x: 0 dc, 1 dc shifted, 2 half-rate carrier, 3 half-rate shifted.
// - a shifted mode moves only the pass band, the signal stays where the unshifted mode puts it.
// - complex input can be moved into positive or negative nyquist regions of the dac rate.
// - i and q stay uncoupled only for dc and the half-rate carrier, all others cross-mix i and q.
// - modulation sits in the interpolation chain, offset a multiple of the input rate.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
module ifm_top
  import ifm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [IFM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [IFM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [IFM_SAMPLE_W-1:0] in_port1,
  input wire logic [IFM_SAMPLE_W-1:0] in_port2,
  output logic [IFM_SAMPLE_W-1:0] dac_i,
  output logic [IFM_SAMPLE_W-1:0] dac_q,
  output logic dac_valid
);
  localparam logic [IFM_ADDR_W-1:0] ADDR_FILTER = IFM_ADDR_W'({IFM_IDX_FILTER_CONFIG, 2'h0});
  localparam logic [IFM_ADDR_W-1:0] ADDR_DATAPATH = IFM_ADDR_W'({IFM_IDX_DATAPATH_CONFIG, 2'h0});
  localparam logic [IFM_ADDR_W-1:0] ADDR_STATUS = IFM_ADDR_W'({IFM_IDX_STATUS, 2'h0});

  // carrier in eighths, shifted flag, reserved flag
  function automatic logic [4:0] decode_mode(input logic [1:0] interp, input logic [3:0] mode);
    logic [4:0] res;
    res = {2'b00, IFM_CARRIER_DC};
    unique case (interp)
      IFM_INTERP_X1: res = {2'b00, IFM_CARRIER_DC};
      IFM_INTERP_X2: begin
        if (mode > IFM_MODE_MAX_X2) begin
          res = {2'b10, IFM_CARRIER_DC};
        end else begin
          res = {1'b0, mode[0], mode[1] ? IFM_CARRIER_HALF : IFM_CARRIER_DC};
        end
      end
      IFM_INTERP_X4: begin
        if (mode > IFM_MODE_MAX_X4) begin
          res = {2'b10, IFM_CARRIER_DC};
        end else begin
          res = {1'b0, mode[0], mode[2:1], 1'b0};
        end
      end
      IFM_INTERP_X8: res = {1'b0, mode[0], mode[3:1]};
    endcase
    return res;
  endfunction

  function automatic logic [IFM_SAMPLE_W-1:0] sat(input logic signed [17:0] v);
    logic [IFM_SAMPLE_W-1:0] o;
    if (v > 18'sd32767) begin
      o = 16'h7FFF;
    end else if (v < -18'sd32768) begin
      o = 16'h8000;
    end else begin
      o = v[15:0];
    end
    return o;
  endfunction

  function automatic logic signed [17:0] root_half(input logic signed [17:0] v);
    logic signed [34:0] p;
    p = v * IFM_ROOT_HALF;
    return p[IFM_ROOT_SHIFT+17:IFM_ROOT_SHIFT];
  endfunction

  // cos(a)*x + sin(a)*y, angle a in eighths of a turn
  function automatic logic [IFM_SAMPLE_W-1:0] mix(input logic [2:0] a, input logic signed [17:0] x,
                                                  input logic signed [17:0] y);
    logic signed [17:0] v;
    v = x;
    unique case (a)
      3'h0: v = x;
      3'h1: v = root_half(x + y);
      3'h2: v = y;
      3'h3: v = root_half(y - x);
      3'h4: v = -x;
      3'h5: v = -root_half(x + y);
      3'h6: v = -y;
      3'h7: v = root_half(x - y);
    endcase
    return sat(v);
  endfunction

  logic [7:0] filter_config_r;
  logic [7:0] datapath_config_r;
  logic underrun_r;
  logic started_r;
  logic aw_held_r;
  logic w_held_r;
  logic [IFM_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic [2:0] cnt_r;
  logic [2:0] phase_r;
  logic il_sel_r;
  logic [IFM_SAMPLE_W-1:0] pend_i_r;
  logic [IFM_SAMPLE_W-1:0] hold_i_r;
  logic [IFM_SAMPLE_W-1:0] hold_q_r;
  logic hold_valid_r;
  logic fifo_s_ready;
  logic fifo_m_valid;
  logic [IFM_FIFO_W-1:0] fifo_m_data;
  logic take_slot;
  logic pop;
  logic do_write;
  logic clr_underrun;
  logic [1:0] interp;
  logic [4:0] dec;
  logic [2:0] carrier;
  logic [2:0] last_cnt;
  logic [2:0] angle;
  logic [5:0] angle_full;
  logic interleave;
  logic real_mode;
  logic [IFM_SAMPLE_W-1:0] word_p1;
  logic [IFM_SAMPLE_W-1:0] word_p2;
  logic [7:0] status;

  assign interp = filter_config_r[IFM_INTERP_LSB +: 2];
  assign dec = decode_mode(interp, filter_config_r[IFM_MODE_LSB +: 4]);
  assign carrier = dec[2:0];
  assign interleave = datapath_config_r[IFM_INTERLEAVE_BIT];
  assign real_mode = datapath_config_r[IFM_REAL_BIT];
  assign last_cnt = 3'((4'h1 << interp) - 4'h1);
  assign take_slot = (cnt_r == 3'h0);
  assign pop = take_slot && fifo_m_valid;
  assign word_p1 = fifo_m_data[IFM_SAMPLE_W-1:0];
  assign word_p2 = fifo_m_data[IFM_FIFO_W-1:IFM_SAMPLE_W];
  // carrier phase advances once per dac sample, so offsets are multiples of the input rate
  assign angle_full = carrier * phase_r;
  assign angle = angle_full[2:0];
  // shifted flag only reported: the carrier ignores it, so the signal does not move
  assign status = {2'b00, dec[4], carrier, dec[3], underrun_r};

  ifm_fifo #(
    .WIDTH(IFM_FIFO_W),
    .DEPTH(IFM_FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_valid(in_valid),
    .s_ready(fifo_s_ready),
    .s_data({in_port2, in_port1}),
    .m_valid(fifo_m_valid),
    .m_ready(take_slot),
    .m_data(fifo_m_data)
  );

  // registered fifo ready, low for a cycle after each accepted word, so the port comes from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= fifo_s_ready && !(in_valid && in_ready);
    end
  end

  // input rate divider: one word slot every 1, 2, 4 or 8 dac cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 3'h0;
      phase_r <= 3'h0;
    end else begin
      cnt_r <= (cnt_r >= last_cnt) ? 3'h0 : cnt_r + 3'h1;
      phase_r <= phase_r + 3'h1;
    end
  end

  // word capture and lane steering
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      il_sel_r <= 1'b0;
      pend_i_r <= '0;
      hold_i_r <= '0;
      hold_q_r <= '0;
      hold_valid_r <= 1'b0;
    end else if (pop) begin
      if (real_mode) begin
        hold_i_r <= word_p1;
        hold_q_r <= '0;
        hold_valid_r <= 1'b1;
        il_sel_r <= 1'b0;
      end else if (interleave) begin
        il_sel_r <= !il_sel_r;
        if (!il_sel_r) begin
          pend_i_r <= word_p1;
        end else begin
          // pair lands together, so each lane updates every second slot
          hold_i_r <= pend_i_r;
          hold_q_r <= word_p1;
          hold_valid_r <= 1'b1;
        end
      end else begin
        hold_i_r <= word_p1;
        hold_q_r <= word_p2;
        hold_valid_r <= 1'b1;
        il_sel_r <= 1'b0;
      end
    end
  end

  // output stage: sample held across the slot, rotated by the carrier each dac cycle outside real mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_i <= '0;
      dac_q <= '0;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= hold_valid_r;
      if (real_mode) begin
        dac_i <= hold_i_r;
        dac_q <= '0;
      end else begin
        // half-rate angles are 0 or 4 only, so no cross terms appear
        dac_i <= mix(angle, 18'(signed'(hold_i_r)), 18'(signed'(hold_q_r)));
        dac_q <= mix(angle, 18'(signed'(hold_q_r)), -18'(signed'(hold_i_r)));
      end
    end
  end

  // underrun: slot found fifo empty after data began; set wins over clear
  assign clr_underrun = do_write && awaddr_r == ADDR_STATUS && wstrb0_r && wdata_r[IFM_ST_UNDERRUN_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underrun_r <= 1'b0;
      started_r <= 1'b0;
    end else begin
      if (pop) begin
        started_r <= 1'b1;
      end
      if (take_slot && !fifo_m_valid && started_r) begin
        underrun_r <= 1'b1;
      end else if (clr_underrun) begin
        underrun_r <= 1'b0;
      end
    end
  end

  // axi write channel: address and data taken in either order
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= IFM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == ADDR_FILTER || awaddr_r == ADDR_DATAPATH || awaddr_r == ADDR_STATUS) ?
                       IFM_RESP_OKAY : IFM_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // configuration registers, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_config_r <= IFM_FILTER_CONFIG_RST;
      datapath_config_r <= IFM_DATAPATH_CONFIG_RST;
    end else if (do_write && wstrb0_r) begin
      if (awaddr_r == ADDR_FILTER) begin
        filter_config_r <= wdata_r[7:0];
      end
      if (awaddr_r == ADDR_DATAPATH) begin
        datapath_config_r <= wdata_r[7:0];
      end
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= IFM_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= IFM_RESP_OKAY;
        unique case (s_axi_araddr)
          ADDR_FILTER: s_axi_rdata <= {24'h000000, filter_config_r};
          ADDR_DATAPATH: s_axi_rdata <= {24'h000000, datapath_config_r};
          ADDR_STATUS: s_axi_rdata <= {24'h000000, status};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= IFM_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

//--- hdl/ifm_pkg.sv
// constants shared by the interpolation/modulation datapath and its fifo
// assumes a 32-bit axi4-lite register bus and one aclk domain
package ifm_pkg;
  localparam int IFM_SAMPLE_W = 16;
  localparam int IFM_FIFO_DEPTH = 8;
  localparam int IFM_FIFO_W = 2 * IFM_SAMPLE_W;
  localparam int IFM_ADDR_W = 8;
  // register indices; byte address is four times the index
  localparam logic [7:0] IFM_IDX_FILTER_CONFIG = 8'h01;
  localparam logic [7:0] IFM_IDX_DATAPATH_CONFIG = 8'h02;
  localparam logic [7:0] IFM_IDX_STATUS = 8'h03;
  // filter_config fields
  localparam int IFM_INTERP_LSB = 6;
  localparam int IFM_MODE_LSB = 2;
  // datapath_config fields
  localparam int IFM_INTERLEAVE_BIT = 6;
  localparam int IFM_REAL_BIT = 5;
  localparam int IFM_INVSINC_BIT = 3;
  // status fields
  localparam int IFM_ST_UNDERRUN_BIT = 0;
  localparam int IFM_ST_SHIFTED_BIT = 1;
  localparam int IFM_ST_CARRIER_LSB = 2;
  localparam int IFM_ST_RESERVED_BIT = 5;
  localparam logic [7:0] IFM_FILTER_CONFIG_RST = 8'h00;
  localparam logic [7:0] IFM_DATAPATH_CONFIG_RST = 8'h00;
  // interpolation factor codes
  localparam logic [1:0] IFM_INTERP_X1 = 2'h0;
  localparam logic [1:0] IFM_INTERP_X2 = 2'h1;
  localparam logic [1:0] IFM_INTERP_X4 = 2'h2;
  localparam logic [1:0] IFM_INTERP_X8 = 2'h3;
  // highest mode code per factor
  localparam logic [3:0] IFM_MODE_MAX_X2 = 4'h3;
  localparam logic [3:0] IFM_MODE_MAX_X4 = 4'h7;
  // carrier in eighths of the dac rate
  localparam logic [2:0] IFM_CARRIER_DC = 3'h0;
  localparam logic [2:0] IFM_CARRIER_HALF = 3'h4;
  // sqrt(2)/2 in q1.15
  localparam logic signed [16:0] IFM_ROOT_HALF = 17'sh05A82;
  localparam int IFM_ROOT_SHIFT = 15;
  localparam logic [1:0] IFM_RESP_OKAY = 2'h0;
  localparam logic [1:0] IFM_RESP_SLVERR = 2'h2;
endpackage

//--- hdl/ifm_fifo.sv
// parameterised sample fifo, flip-flop storage, registered full and empty
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module ifm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [WIDTH-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic full_r;
  logic empty_r;
  logic push;
  logic pop;

  assign push = s_valid && !full_r;
  assign pop = m_ready && !empty_r;
  assign s_ready = !full_r;
  assign m_valid = !empty_r;
  assign m_data = mem_r[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + (AW+1)'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - (AW+1)'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= s_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      end
      count_r <= count_nxt;
      full_r <= (count_nxt == (AW+1)'(DEPTH));
      empty_r <= (count_nxt == '0);
    end
  end
endmodule

//--- sim/ifm_top_asserts.sv
// port checker for ifm_top, bound to every instance
// assumes one aclk domain with synchronous active-low aresetn
`timescale 1ns/100ps
module ifm_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic dac_valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since the last accepted word, saturating
  logic [3:0] since_acc_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_acc_r <= 4'hF;
    end else if (in_valid && in_ready) begin
      since_acc_r <= 4'h0;
    end else if (since_acc_r != 4'hF) begin
      since_acc_r <= since_acc_r + 4'h1;
    end
  end
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read response");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_write_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_accept_gap: assert property (in_valid && in_ready |=> !in_ready)
    else $error("word accepted back to back");
  a_dac_sticky: assert property (dac_valid |=> dac_valid)
    else $error("output valid dropped");
  a_dac_cause: assert property ($rose(dac_valid) |-> since_acc_r < 4'hC)
    else $error("output valid without input word");
endmodule
bind ifm_top ifm_top_asserts u_chk (.*);

//--- sim/ifm_src_model.sv
// upstream sample source feeding ports 1 and 2
// assumes in_ready from ifm_top and one aclk domain
`timescale 1ns/100ps
module ifm_src_model
  import ifm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  input wire logic [3:0] gap_len,
  input wire logic [IFM_SAMPLE_W-1:0] word_a,
  input wire logic [IFM_SAMPLE_W-1:0] word_b,
  input wire logic [IFM_SAMPLE_W-1:0] word_q,
  input wire logic in_ready,
  output logic in_valid,
  output logic [IFM_SAMPLE_W-1:0] in_port1,
  output logic [IFM_SAMPLE_W-1:0] in_port2
);
  logic tog_r;
  logic [3:0] gap_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_valid <= 1'b0;
      tog_r <= 1'b0;
      gap_r <= 4'h0;
    end else if (in_valid && in_ready) begin
      in_valid <= 1'b0;
      tog_r <= !tog_r;
      // released lines flip so no stale word looks valid
      in_port1 <= ~in_port1;
      in_port2 <= ~in_port2;
      gap_r <= gap_len;
    end else if (in_valid) begin
      in_valid <= 1'b1;
    end else if (gap_r != 4'h0) begin
      gap_r <= gap_r - 4'h1;
    end else if (en) begin
      in_valid <= 1'b1;
      in_port1 <= tog_r ? word_b : word_a;
      in_port2 <= word_q;
    end
  end
endmodule

//--- sim/interp_filter_modulator_bench.sv
// self-checking bench for ifm_top with a sample source model
// assumes ifm_pkg, ifm_top, ifm_src_model and the bound checker
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; $display("ERROR %0t mismatch", $time); end end
module interp_filter_modulator_bench;
  import ifm_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, en;
  logic awready, wready, bvalid, arready, rvalid, in_valid, in_ready, dac_valid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [3:0] gap;
  logic [15:0] wa, wb, wq, p1, p2, dac_i, dac_q;
  int err_total, tests_run, hits, lo;
  // filter_config value, then expected status bits 5:1
  logic [15:0] rows [12] = '{16'h4000, 16'h4401, 16'h4808, 16'h4C09, 16'h5010, 16'h8C05,
    16'h980C, 16'h9C0D, 16'hA010, 16'hC802, 16'hE80A, 16'hFC0F};
  // filter_config, then a dac_i value the carrier must produce
  logic [23:0] rot [5] = '{24'h880800, 24'h8C0800, 24'h98F800, 24'h48F000, 24'hC80800};
  ifm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_valid(in_valid),
    .in_ready(in_ready), .in_port1(p1), .in_port2(p2), .dac_i(dac_i), .dac_q(dac_q), .dac_valid(dac_valid));
  ifm_src_model src (.aclk(aclk), .aresetn(aresetn), .en(en), .gap_len(gap), .word_a(wa), .word_b(wb),
    .word_q(wq), .in_ready(in_ready), .in_valid(in_valid), .in_port1(p1), .in_port2(p2));
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    // late ready lets the response be seen waiting
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    repeat (2) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] f, input logic [7:0] dp);
    wr(8'h04, {24'h0, f}, r);
    wr(8'h08, {24'h0, dp}, r);
  endtask
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    print_verdict();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, en} = '0;
    {awaddr, araddr, wdata, gap, wa, wb, wq} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(dac_valid, 1'b0)
    rd(8'h04, d, r);
    `CHK(d, 32'h0)
    rd(8'h08, d, r);
    `CHK(d, 32'h0)
    foreach (rows[i]) begin
      wr(8'h04, {24'h0, rows[i][15:8]}, r);
      rd(8'h04, d, r);
      `CHK(d[7:0], rows[i][15:8])
      rd(8'h0C, d, r);
      `CHK(d[5:1], rows[i][4:0])
    end
    wr(8'h10, 32'hFF, r);
    `CHK(r, IFM_RESP_SLVERR)
    rd(8'h10, d, r);
    `CHK(r, IFM_RESP_SLVERR)
    wa <= 16'h1234;
    wb <= 16'h1234;
    wq <= 16'h0567;
    en <= 1'b1;
    cfg(8'h3C, 8'h00);
    repeat (40) @(posedge aclk);
    `CHK({dac_valid, dac_i, dac_q}, {1'b1, 16'h1234, 16'h0567})
    cfg(8'hC8, 8'h20);
    repeat (40) @(posedge aclk);
    repeat (4) begin
      @(posedge aclk);
      `CHK({dac_i, dac_q}, {16'h1234, 16'h0000})
    end
    wa <= 16'h1000;
    wb <= 16'h1000;
    wq <= 16'h0800;
    foreach (rot[i]) begin
      cfg(rot[i][23:16], 8'h00);
      repeat (40) @(posedge aclk);
      hits = 0;
      repeat (8) begin
        @(posedge aclk);
        if (dac_i === rot[i][15:0]) hits++;
      end
      `CHK(hits > 0, 1'b1)
    end
    // slow source at 8x still outruns the slots, so the fifo fills and one word is taken per 8-cycle slot
    gap <= 4'h2;
    cfg(8'hC0, 8'h00);
    repeat (40) @(posedge aclk);
    lo = 0;
    repeat (16) begin
      @(posedge aclk);
      if (in_valid && in_ready) lo++;
    end
    `CHK(lo, 2)
    en <= 1'b0;
    repeat (100) @(posedge aclk);
    rd(8'h0C, d, r);
    `CHK({dac_valid, d[0]}, 2'b11)
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    gap <= 4'h0;
    wa <= 16'h0111;
    wb <= 16'h0222;
    wq <= 16'h7777;
    cfg(8'h00, 8'h40);
    en <= 1'b1;
    repeat (40) @(posedge aclk);
    `CHK({dac_i, dac_q}, {16'h0111, 16'h0222})
    print_verdict();
  end
endmodule
